// ===== hw/evtr_fifo.sv
// Descriptor FIFO with a registered read stage.
// Assumes the core clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module evtr_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic                       s_valid,
    output      logic                       s_ready,
    input  wire logic [W-1:0]               s_data,
    output      logic                       m_valid,
    input  wire logic                       m_ready,
    output      logic [W-1:0]               m_data,
    output      logic [$clog2(DEPTH):0]     level
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          ov_q, ov_d, rdy_q, rdy_d;
    logic [W-1:0]  od_q, od_d;
    logic          push, load;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        push  = s_valid && rdy_q;
        load  = (cnt_q != '0) && (!ov_q || m_ready);
        wp_d  = push ? wp_q + AW'(1) : wp_q;
        rp_d  = load ? rp_q + AW'(1) : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(load);
        ov_d  = load ? 1'b1 : (m_ready ? 1'b0 : ov_q);
        od_d  = load ? mem[rp_q] : od_q;
        // Ready is registered, so it looks at the count after this edge.
        rdy_d = cnt_d < (AW+1)'(DEPTH);
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= s_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            ov_q  <= 1'b0;
            od_q  <= '0;
            rdy_q <= 1'b0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            ov_q  <= ov_d;
            od_q  <= od_d;
            rdy_q <= rdy_d;
        end
    end

    assign s_ready = rdy_q;
    assign m_valid = ov_q;
    assign m_data  = od_q;
    assign level   = cnt_q;
endmodule

// ===== hw/evtr_pkg.sv
// Shared constants and types of the egress VLAN tag and pacing block.
// Assumes a single core clock; all users import the whole package.
package evtr_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register indexes; the byte address is four times the index.
    localparam logic [13:0] IDX_RULES    = 14'h1c0c;
    localparam logic [13:0] IDX_PACE01   = 14'h1c0d;
    localparam logic [13:0] IDX_PACE23   = 14'h1c0e;
    localparam logic [13:0] IDX_PACE_CTL = 14'h1c20;
    localparam int          IDX_LSB      = 2;

    localparam logic [31:0] RULES_MASK = 32'h007f_7f7f;
    localparam logic [31:0] PACE_MASK  = 32'h03ff_ffff;
    localparam logic [31:0] RST_ZERO   = 32'h0000_0000;

    // Per-port control group layout inside the tagging register.
    localparam int PORT_STRIDE = 8;
    localparam int CTL_W       = 7;
    localparam int CTL_TYPE    = 0;
    localparam int CTL_CTAG    = 2;
    localparam int CTL_CPRI    = 3;
    localparam int CTL_CVID    = 4;
    localparam int CTL_INS     = 5;
    localparam int CTL_SEL     = 6;
    localparam int TYPE_W      = 2;

    // Pacing fields.
    localparam int RATE_W      = 13;
    localparam int RATE_LO     = 0;
    localparam int RATE_HI     = 13;
    localparam int PACE_W      = 25;
    localparam int PCTL_EN     = 0;
    localparam int PCTL_BUSY   = 1;
    localparam int PCTL_LVL    = 8;

    // Timing: pacing counts in units of 20 ns, drained each clock.
    localparam int PACE_UNIT_NS = 20;
    localparam int CLK_NS       = 100;
    localparam logic [PACE_W-1:0] PACE_STEP =
        PACE_W'(CLK_NS / PACE_UNIT_NS);

    localparam int FIFO_DEPTH = 32;
    localparam logic [1:0] PORT0 = 2'h0;

    typedef enum logic [1:0] {
        PT_DUMB   = 2'b00,
        PT_ACCESS = 2'b01,
        PT_HYBRID = 2'b10,
        PT_CPU    = 2'b11
    } evtr_ptype_t;

    typedef enum logic [1:0] {
        TK_UNTAGGED = 2'b00,
        TK_PRIO     = 2'b01,
        TK_REGULAR  = 2'b10,
        TK_SPECIAL  = 2'b11
    } evtr_kind_t;

    typedef enum logic [2:0] {
        ACT_KEEP    = 3'h0,
        ACT_STRIP   = 3'h1,
        ACT_INSERT  = 3'h2,
        ACT_RETAG   = 3'h3,
        ACT_SPECIAL = 3'h4
    } evtr_act_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } evtr_bus_t;

    typedef struct packed {
        logic [1:0]  eport;
        logic [1:0]  iport;
        evtr_kind_t  kind;
        logic [1:0]  queue;
        logic        untag;
        logic [11:0] vlan_identifier;
        logic [2:0]  pri;
        logic [11:0] ivid;
        logic [2:0]  ipri;
        logic [11:0] evid;
        logic [2:0]  epri;
        logic [10:0] len;
    } evtr_desc_t;

    typedef struct packed {
        evtr_act_t   action;
        logic [11:0] vlan_identifier;
        logic [2:0]  pri;
    } evtr_dec_t;

endpackage

// ===== hw/evtr_top.sv
// Egress VLAN tagging decision and port 0 per-queue egress pacing.
// Assumes descriptors from core-clock logic and an Avalon-MM master.
// Summary of operation
// - Change-tag lets VLAN_IDENTIFIER/priority change act on regular tagged packets only.
// - Tag select, insert and change controls act only on hybrid ports.
// - Dumb port passes packets, strips special tags from the MII port.
// - Access port strips every tag, special tags included.
// - Hybrid port inserts, removes or changes tags per its control bits.
// - CPU port adds a special tag naming the ingress port.
// - Port 1 controls sit at bits 14 to 8.
// - Port 0 controls sit at bits 6 to 0; bits 15 and 7 read zero.
// - Pacing time per byte is field value plus one, times 20 ns.
// - Port 0 queues 0 and 1 use bits 12:0 and 25:13, reset zero.
// - Port 0 queues 2 and 3 use the second rate register alike.
// - Select 0 takes ingress VLAN_IDENTIFIER/priority, 1 takes egress defaults.
// - Insert tags untagged packets when the untag bit is clear.
// - VLAN_IDENTIFIER change replaces regular VIDs; priority tagged always; untag strips.
// - Priority change hits priority tagged; regular needs change-tag, no untag.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module evtr_top (
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic [15:0]         avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output      logic [31:0]         avs_readdata,
    output      logic                avs_waitrequest,
    input  wire logic                in_valid,
    output      logic                in_ready,
    input  wire logic [1:0]          in_egress_port,
    input  wire logic [1:0]          in_ingress_port,
    input  wire evtr_pkg::evtr_kind_t in_tag_kind,
    input  wire logic [1:0]          in_queue,
    input  wire logic                in_untag,
    input  wire logic [11:0]         in_vid,
    input  wire logic [2:0]          in_pri,
    input  wire logic [11:0]         in_ingr_dflt_vid,
    input  wire logic [2:0]          in_ingr_pri,
    input  wire logic [11:0]         in_egr_dflt_vid,
    input  wire logic [2:0]          in_egr_dflt_pri,
    input  wire logic [10:0]         in_len,
    output      logic                out_valid,
    input  wire logic                out_ready,
    output      logic [1:0]          out_egress_port,
    output      evtr_pkg::evtr_act_t out_action,
    output      logic [11:0]         out_vid,
    output      logic [2:0]          out_pri,
    output      logic [1:0]          out_src_port,
    output      logic [1:0]          out_queue,
    output      logic [10:0]         out_len
);
    import evtr_pkg::*;

    localparam int DESC_W = $bits(evtr_desc_t);
    localparam int LVL_W  = $clog2(FIFO_DEPTH) + 1;

    evtr_bus_t         bus_q, bus_d;
    logic              wait_q, wait_d;
    logic [31:0]       rdata_q, rdata_d, rd_val;
    logic [31:0]       rules_q, rules_d, p01_q, p01_d, p23_q, p23_d;
    logic              pen_q, pen_d;
    logic [13:0]       idx;
    logic [PACE_W-1:0] pace_q, pace_d;
    logic [RATE_W-1:0] rate;
    evtr_desc_t        in_desc, hd;
    logic              hd_valid, iss;
    logic [LVL_W-1:0]  level;
    logic [CTL_W-1:0]  hd_ctl;
    evtr_dec_t         dec;
    logic              ov_q, ov_d;
    evtr_desc_t        od_q, od_d;
    evtr_dec_t         odec_q, odec_d;

    // Control group of one egress port; the unused code 3 reads as dumb.
    function automatic logic [CTL_W-1:0] port_ctl(input logic [31:0] r,
                                                  input logic [1:0]  p);
        port_ctl = '0;
        if (p != 2'h3) begin
            port_ctl = r[32'(p) * PORT_STRIDE +: CTL_W];
        end
    endfunction

    function automatic evtr_dec_t decide(input logic [CTL_W-1:0] c,
                                         input evtr_desc_t       d);
        evtr_dec_t   r;
        logic [11:0] sv;
        logic [2:0]  sp;
        sv = c[CTL_SEL] ? d.evid : d.ivid;
        sp = c[CTL_SEL] ? d.epri : d.ipri;
        r.action = ACT_KEEP;
        r.vlan_identifier    = d.vlan_identifier;
        r.pri    = d.pri;
        case (evtr_ptype_t'(c[CTL_TYPE +: TYPE_W]))
            PT_DUMB: begin
                if (d.kind == TK_SPECIAL) begin
                    r.action = ACT_STRIP;
                end
            end
            PT_ACCESS: begin
                if (d.kind != TK_UNTAGGED) begin
                    r.action = ACT_STRIP;
                end
            end
            PT_HYBRID: begin
                if (d.kind == TK_UNTAGGED) begin
                    if (c[CTL_INS] && !d.untag) begin
                        r.action = ACT_INSERT;
                        r.vlan_identifier    = sv;
                        r.pri    = sp;
                    end
                end else if (d.kind == TK_PRIO) begin
                    r.action = ACT_RETAG;
                    r.vlan_identifier    = sv;
                    if (c[CTL_CPRI]) begin
                        r.pri = sp;
                    end
                end else if (d.kind == TK_REGULAR) begin
                    if (c[CTL_CTAG] && (c[CTL_CVID] || c[CTL_CPRI])) begin
                        if (d.untag) begin
                            r.action = ACT_STRIP;
                        end else begin
                            r.action = ACT_RETAG;
                            if (c[CTL_CVID]) begin
                                r.vlan_identifier = sv;
                            end
                            if (c[CTL_CPRI]) begin
                                r.pri = sp;
                            end
                        end
                    end
                end else begin
                    r.action = ACT_STRIP;
                end
            end
            default: begin
                r.action = ACT_SPECIAL;
            end
        endcase
        decide = r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register slave: one wait state, write lands on the release edge.
    assign idx = avs_address[15:IDX_LSB];

    always_comb begin
        rd_val = RST_ZERO;
        if (idx == IDX_RULES) begin
            rd_val = rules_q;
        end else if (idx == IDX_PACE01) begin
            rd_val = p01_q;
        end else if (idx == IDX_PACE23) begin
            rd_val = p23_q;
        end else if (idx == IDX_PACE_CTL) begin
            rd_val[PCTL_EN]   = pen_q;
            rd_val[PCTL_BUSY] = pace_q != '0;
            rd_val[PCTL_LVL +: LVL_W] = level;
        end
    end

    always_comb begin
        bus_d   = bus_q;
        rdata_d = rdata_q;
        rules_d = rules_q;
        p01_d   = p01_q;
        p23_d   = p23_q;
        pen_d   = pen_q;
        case (bus_q)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_d   = BUS_ACK;
                    rdata_d = avs_read ? rd_val : RST_ZERO;
                end
            end
            BUS_ACK: begin
                bus_d = BUS_IDLE;
                if (avs_write) begin
                    if (idx == IDX_RULES) begin
                        rules_d = avs_writedata & RULES_MASK;
                    end else if (idx == IDX_PACE01) begin
                        p01_d = avs_writedata & PACE_MASK;
                    end else if (idx == IDX_PACE23) begin
                        p23_d = avs_writedata & PACE_MASK;
                    end else if (idx == IDX_PACE_CTL) begin
                        pen_d = avs_writedata[PCTL_EN];
                    end
                end
            end
            default: begin
                bus_d = BUS_IDLE;
            end
        endcase
        wait_d = bus_d != BUS_ACK;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bus_q   <= BUS_IDLE;
            wait_q  <= 1'b1;
            rdata_q <= RST_ZERO;
            rules_q <= RST_ZERO;
            p01_q   <= RST_ZERO;
            p23_q   <= RST_ZERO;
            pen_q   <= 1'b0;
        end else begin
            bus_q   <= bus_d;
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
            rules_q <= rules_d;
            p01_q   <= p01_d;
            p23_q   <= p23_d;
            pen_q   <= pen_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Descriptor queue.
    assign in_desc = '{eport: in_egress_port, iport: in_ingress_port,
                       kind: in_tag_kind, queue: in_queue,
                       untag: in_untag, vlan_identifier: in_vid, pri: in_pri,
                       ivid: in_ingr_dflt_vid, ipri: in_ingr_pri,
                       evid: in_egr_dflt_vid, epri: in_egr_dflt_pri,
                       len: in_len};

    evtr_fifo #(.W(DESC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk     (ref_clk),
        .resetn  (resetn),
        .s_valid (in_valid),
        .s_ready (in_ready),
        .s_data  (in_desc),
        .m_valid (hd_valid),
        .m_ready (iss),
        .m_data  (hd),
        .level   (level)
    );

    ////////////////////////////////////////////////////////////////////
    // Issue stage and pacing. Pacing holds the whole queue head, so a
    // paced port 0 packet also delays the packets queued behind it.
    always_comb begin
        hd_ctl = port_ctl(rules_q, hd.eport);
        dec    = decide(hd_ctl, hd);
        iss    = hd_valid && (pace_q == '0) && (!ov_q || out_ready);
        case (hd.queue)
            2'h0:    rate = p01_q[RATE_LO +: RATE_W];
            2'h1:    rate = p01_q[RATE_HI +: RATE_W];
            2'h2:    rate = p23_q[RATE_LO +: RATE_W];
            default: rate = p23_q[RATE_HI +: RATE_W];
        endcase
        pace_d = (pace_q > PACE_STEP) ? pace_q - PACE_STEP : '0;
        if (iss && hd.eport == PORT0 && pen_q) begin
            pace_d = PACE_W'(hd.len) * (PACE_W'(rate) + PACE_W'(1));
        end
        ov_d   = iss ? 1'b1 : (out_ready ? 1'b0 : ov_q);
        od_d   = iss ? hd : od_q;
        odec_d = iss ? dec : odec_q;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pace_q <= '0;
            ov_q   <= 1'b0;
            od_q   <= '0;
            odec_q <= '0;
        end else begin
            pace_q <= pace_d;
            ov_q   <= ov_d;
            od_q   <= od_d;
            odec_q <= odec_d;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign out_valid       = ov_q;
    assign out_egress_port = od_q.eport;
    assign out_action      = odec_q.action;
    assign out_vid         = odec_q.vlan_identifier;
    assign out_pri         = odec_q.pri;
    assign out_src_port    = od_q.iport;
    assign out_queue       = od_q.queue;
    assign out_len         = od_q.len;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    logic [1:0] ht;
    assign ht = hd_ctl[CTL_TYPE +: TYPE_W];

    dumb_pass_a: assert property (iss && ht == PT_DUMB
        && hd.kind != TK_SPECIAL |=> out_action == ACT_KEEP)
        else $error("dumb port modified a packet");
    dumb_strip_a: assert property (iss && ht == PT_DUMB
        && hd.kind == TK_SPECIAL |=> out_action == ACT_STRIP)
        else $error("dumb port kept a special tag");
    access_strip_a: assert property (iss && ht == PT_ACCESS
        && hd.kind != TK_UNTAGGED |=> out_action == ACT_STRIP)
        else $error("access port kept a tag");
    cpu_source_a: assert property (iss && ht == PT_CPU |=>
        out_action == ACT_SPECIAL && out_src_port == $past(hd.iport))
        else $error("cpu port special tag wrong");
    hybrid_only_a: assert property (iss && ht != PT_HYBRID |=>
        out_action != ACT_INSERT && out_action != ACT_RETAG)
        else $error("tag change on non-hybrid port");
    chg_tag_a: assert property (iss && ht == PT_HYBRID
        && hd.kind == TK_REGULAR && !hd_ctl[CTL_CTAG]
        |=> out_action == ACT_KEEP)
        else $error("regular tag changed without change-tag");
    insert_sel_a: assert property (iss && ht == PT_HYBRID
        && hd.kind == TK_UNTAGGED && hd_ctl[CTL_INS] && !hd.untag
        && hd_ctl[CTL_SEL] |=> out_action == ACT_INSERT
        && out_vid == $past(hd.evid) && out_pri == $past(hd.epri))
        else $error("insert did not take egress defaults");
    untag_strip_a: assert property (iss && ht == PT_HYBRID
        && hd.kind == TK_REGULAR && hd_ctl[CTL_CTAG]
        && hd_ctl[CTL_CVID] && hd.untag |=> out_action == ACT_STRIP)
        else $error("untag bit did not strip");
    prio_vid_a: assert property (iss && ht == PT_HYBRID
        && hd.kind == TK_PRIO && !hd_ctl[CTL_SEL] |=>
        out_vid == $past(hd.ivid) && (out_pri == $past(hd.ipri)
        || !$past(hd_ctl[CTL_CPRI])))
        else $error("priority tagged packet not retagged");
    pace_q3_a: assert property (iss && pen_q && hd.eport == PORT0
        && hd.queue == 2'h3 |=> pace_q == PACE_W'($past(hd.len))
        * (PACE_W'($past(p23_q[RATE_HI +: RATE_W])) + PACE_W'(1)))
        else $error("queue 3 pacing count wrong");
    pace_hold_a: assert property (pace_q != '0 |-> !iss)
        else $error("issue while pacing busy");
    pace_off_a: assert property (!pen_q && pace_q == '0
        |=> pace_q == '0)
        else $error("pacing active while disabled");
    rsv_zero_a: assert property ((rules_q & ~RULES_MASK) == '0
        && (p01_q & ~PACE_MASK) == '0)
        else $error("reserved bits set");

    insert_c: cover property (iss && dec.action == ACT_INSERT);
    special_c: cover property (iss && dec.action == ACT_SPECIAL);
    pace_c: cover property (hd_valid && pace_q != '0);
    write_c: cover property (bus_q == BUS_ACK && avs_write);
endmodule

// ===== sim/egress_vlan_tag_and_rate_config_tb.sv
// Self-checking bench for the egress tagging and pacing block.
// Assumes evtr_pkg and the design files are compiled before it.
`timescale 1ns/1ps
`define CHK(g, e) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
end

module egress_vlan_tag_and_rate_config_tb;
    import evtr_pkg::*;

    logic        ref_clk;
    logic        resetn;
    logic [15:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        in_valid;
    logic        in_ready;
    logic        out_valid;
    logic        out_ready;
    evtr_desc_t  cur;
    evtr_act_t   out_action;
    logic [1:0]  out_egress_port;
    logic [1:0]  out_src_port;
    logic [1:0]  out_queue;
    logic [11:0] out_vid;
    logic [2:0]  out_pri;
    logic [10:0] out_len;
    int          mismatches;
    int          check_count;
    int          cyc;

    evtr_top i_dut (
        .ref_clk, .resetn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .in_valid,
        .in_ready, .in_egress_port(cur.eport), .in_ingress_port(cur.iport),
        .in_tag_kind(cur.kind), .in_queue(cur.queue),
        .in_untag(cur.untag), .in_vid(cur.vlan_identifier), .in_pri(cur.pri),
        .in_ingr_dflt_vid(cur.ivid), .in_ingr_pri(cur.ipri),
        .in_egr_dflt_vid(cur.evid), .in_egr_dflt_pri(cur.epri),
        .in_len(cur.len), .out_valid, .out_ready, .out_egress_port,
        .out_action, .out_vid, .out_pri, .out_src_port, .out_queue,
        .out_len
    );

    ////////////////////////////////////////////////////////////////////
    initial ref_clk = 1'b0;
    always #50 ref_clk = ~ref_clk;

    // A hang anywhere ends the run as a failure.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            results();
        end
    end

    task automatic results();
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic bus(input logic [13:0] idx, input logic wr,
                       input logic [31:0] wd, output logic [31:0] rd);
        avs_address   <= {idx, 2'b00};
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= wd;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Leaves in_valid high; the caller lowers it.
    task automatic push(input evtr_desc_t d);
        cur      <= d;
        in_valid <= 1'b1;
        do @(posedge ref_clk); while (in_ready !== 1'b1);
    endtask

    task automatic wait_out();
        do @(posedge ref_clk); while (out_valid !== 1'b1);
    endtask

    function automatic evtr_dec_t exp_dec(logic [31:0] r, evtr_desc_t d);
        logic [6:0] c;
        evtr_dec_t  e;
        c = (d.eport == 2'd3) ? 7'h00 : r[d.eport*PORT_STRIDE +: CTL_W];
        e.action = ACT_KEEP;
        e.vlan_identifier    = c[CTL_SEL] ? d.evid : d.ivid;
        e.pri    = c[CTL_SEL] ? d.epri : d.ipri;
        case (c[1:0])
            PT_DUMB:   if (d.kind == TK_SPECIAL) e.action = ACT_STRIP;
            PT_ACCESS: if (d.kind != TK_UNTAGGED) e.action = ACT_STRIP;
            PT_CPU:    e.action = ACT_SPECIAL;
            default: begin
                if (d.kind == TK_UNTAGGED && c[CTL_INS] && !d.untag)
                    e.action = ACT_INSERT;
                if (d.kind == TK_SPECIAL)
                    e.action = ACT_STRIP;
                if (d.kind == TK_PRIO)
                    e.action = ACT_RETAG;
                if (d.kind == TK_REGULAR && c[CTL_CTAG]
                    && (c[CTL_CVID] || c[CTL_CPRI]))
                    e.action = d.untag ? ACT_STRIP : ACT_RETAG;
                if (d.kind == TK_REGULAR && !c[CTL_CVID])
                    e.vlan_identifier = d.vlan_identifier;
                if (d.kind != TK_UNTAGGED && !c[CTL_CPRI])
                    e.pri = d.pri;
            end
        endcase
        return e;
    endfunction

    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] rd;
        logic [31:0] r;
        logic [31:0] corner [4];
        logic [13:0] idx [4];
        int          pq [4];
        int          pn [4];
        int          t0;
        int          acc;
        int          k;
        evtr_desc_t  d;
        evtr_dec_t   e;
        corner = '{32'h0000_0000, 32'hffff_ffff, 32'h007e_7e7e, 32'h0001_0101};
        idx = '{IDX_RULES, IDX_PACE01, IDX_PACE23, 14'h1c0b};
        pq = '{1, 3, 0, 2};
        pn = '{10, 20, 6, 0};
        {resetn, avs_read, avs_write, in_valid} = '0;
        {avs_address, avs_writedata, cur, mismatches, check_count} = '0;
        {cyc, out_ready} = 1;
        void'($urandom(24));
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        // Reset values, reserved bits and an unmapped index.
        foreach (idx[i]) begin
            bus(idx[i], 1'b0, 32'h0, rd);
            `CHK(rd, RST_ZERO)
            bus(idx[i], 1'b1, 32'hffff_ffff, rd);
            bus(idx[i], 1'b0, 32'h0, rd);
            r = (i == 0) ? RULES_MASK : (i == 3) ? RST_ZERO : PACE_MASK;
            `CHK(rd, r)
        end
        // Tagging decisions, corner settings first, then random.
        for (int n = 0; n < 60; n++) begin
            r = (n < 4) ? corner[n] : $urandom;
            bus(IDX_RULES, 1'b1, r, rd);
            bus(IDX_RULES, 1'b0, 32'h0, rd);
            `CHK(rd, r & RULES_MASK)
            repeat (4) begin
                d = evtr_desc_t'(65'({$urandom, $urandom, $urandom}));
                d.iport = 2'($urandom_range(2, 0));
                e = exp_dec(r & RULES_MASK, d);
                push(d);
                in_valid <= 1'b0;
                wait_out();
                `CHK(out_action, e.action)
                if (e.action inside {ACT_INSERT, ACT_RETAG}) begin
                    `CHK({out_vid, out_pri}, {e.vlan_identifier, e.pri})
                end
                `CHK(out_src_port, d.iport)
                `CHK({out_egress_port, out_queue, out_len}, {d.eport, d.queue, d.len})
            end
        end
        // Pacing gap between two port 0 packets of 10 bytes.
        bus(IDX_PACE01, 1'b1, 32'h0000_8002, rd);
        bus(IDX_PACE23, 1'b1, 32'h0001_2001, rd);
        for (int i = 0; i < 4; i++) begin
            bus(IDX_PACE_CTL, 1'b1, (i < 3) ? 32'h0000_0001 : 32'h0, rd);
            d = '0;
            d.queue = 2'(pq[i]);
            d.len = 11'd10;
            push(d);
            push(d);
            in_valid <= 1'b0;
            wait_out();
            t0 = cyc;
            wait_out();
            `CHK(cyc - t0 >= pn[i] && cyc - t0 <= pn[i] + 3, 1'b1)
        end
        // Fill the buffer against a stalled output, then drain it.
        out_ready <= 1'b0;
        acc = 0;
        for (k = 0; k < 40 && acc == k; k++) begin
            cur.len  <= 11'(k);
            in_valid <= 1'b1;
            @(posedge ref_clk);
            if (in_ready === 1'b1)
                acc++;
        end
        in_valid <= 1'b0;
        `CHK(acc, FIFO_DEPTH + 2)
        bus(IDX_PACE_CTL, 1'b0, 32'h0, rd);
        `CHK(rd[13:8], 6'(FIFO_DEPTH))
        k = 0;
        while (k < acc) begin
            out_ready <= 1'($urandom);
            @(posedge ref_clk);
            if (out_valid === 1'b1 && out_ready === 1'b1) begin
                `CHK(out_len, 11'(k))
                k++;
            end
        end
        out_ready <= 1'b1;
        bus(IDX_PACE_CTL, 1'b0, 32'h0, rd);
        `CHK({rd[13:8], in_ready, out_valid}, 8'h02)
        results();
    end
endmodule
